// File: hw/led_scan_pkg.sv
package led_scan_pkg;

	// Register byte addresses
	localparam logic [7:0] ADDR_CONST_FORCE_LOW  = 8'h77;
	localparam logic [7:0] ADDR_CONST_FORCE_HIGH = 8'h78;
	localparam logic [7:0] ADDR_ROW_MASK_LOW     = 8'h79;
	localparam logic [7:0] ADDR_ROW_MASK_HIGH    = 8'h7A;
	localparam logic [7:0] ADDR_COL_SCAN_COUNT   = 8'h7E;

	// Reset values
	localparam logic [7:0] RST_CONST_FORCE_LOW  = 8'h00;
	localparam logic [4:0] RST_CONST_FORCE_HIGH = 5'h00;
	localparam logic [7:0] RST_ROW_MASK_LOW     = 8'h00;
	localparam logic [3:0] RST_ROW_MASK_HIGH    = 4'h0;
	localparam logic       RST_ROW_MASK_LEVEL   = 1'b0;
	localparam logic [3:0] RST_COL_SCAN_COUNT   = 4'hB;

	// Field positions and widths
	localparam int ROW_MASK_HIGH_LSB   = 0;
	localparam int ROW_MASK_HIGH_W     = 4;
	localparam int ROW_MASK_LEVEL_POS  = 4;
	localparam int CONST_FORCE_HIGH_W  = 5;
	localparam int COL_SCAN_LSB        = 0;
	localparam int COL_SCAN_W          = 4;

	// Matrix geometry
	localparam int NUM_ROWS  = 12;
	localparam int NUM_LINES = 13;
	localparam logic [3:0] COL_LAST_ALL = 4'hB;

	// Register access strobe with its address and data
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

endpackage

// File: hw/col_scan_counter.sv
module col_scan_counter
	import led_scan_pkg::*;
#(
	parameter int COL_W = 4
) (
	input  wire logic             clk_sys_i,
	input  wire logic             rst_n_i,
	input  wire logic             scan_tick_i,
	input  wire logic [COL_W-1:0] last_col_i,
	output logic      [COL_W-1:0] col_idx_o
);

	logic [COL_W-1:0] col_idx;
	logic [COL_W-1:0] next_col_idx;

	if (COL_W < 4) begin : g_bad_width
		$error("col_scan_counter needs at least four bits");
	end

	// Wraps after the last enabled column; a shortened limit wraps on the next scan tick
	always_comb begin
		next_col_idx = col_idx;
		if (scan_tick_i) begin
			if (col_idx >= last_col_i)
				next_col_idx = '0;
			else
				next_col_idx = col_idx + COL_W'(1);
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i)
			col_idx <= '0;
		else
			col_idx <= next_col_idx;
	end

	assign col_idx_o = col_idx;

	col_wrap_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		scan_tick_i && col_idx >= last_col_i |=> col_idx == '0)
		else $error("column counter did not wrap after last column");

endmodule

// File: hw/led_matrix_row_mask_scan_ctrl.sv
module led_matrix_row_mask_scan_ctrl
	import led_scan_pkg::*;
(
	input  wire logic                          clk_sys_i,
	input  wire logic                          rst_n_i,
	input  wire led_scan_pkg::reg_req_s        reg_req_i,
	input  wire logic                          scan_tick_i,
	input  wire logic                          scroll_active_i,
	input  wire logic                          detect_en_i,
	input  wire logic [led_scan_pkg::NUM_ROWS-1:0]  matrix_row_ctrl_i,
	output logic      [7:0]                    reg_rdata_o,
	output logic                               reg_rvalid_o,
	output logic      [led_scan_pkg::NUM_ROWS-1:0]  row_switch_control_o,
	output logic      [led_scan_pkg::NUM_LINES-1:0] line_const_mode_o,
	output logic      [3:0]                    col_idx_o
);

	import led_scan_pkg::*;

	// Register state
	logic [7:0]                    const_force_low;
	logic [CONST_FORCE_HIGH_W-1:0] const_force_high;
	logic [7:0]                    row_mask_low_rows;
	logic [ROW_MASK_HIGH_W-1:0]    row_mask_high_rows;
	logic                          row_mask_level;
	logic [COL_SCAN_W-1:0]         column_scan_count;

	logic [7:0]                    next_const_force_low;
	logic [CONST_FORCE_HIGH_W-1:0] next_const_force_high;
	logic [7:0]                    next_row_mask_low_rows;
	logic [ROW_MASK_HIGH_W-1:0]    next_row_mask_high_rows;
	logic                          next_row_mask_level;
	logic [COL_SCAN_W-1:0]         next_column_scan_count;

	// Read path state
	logic [7:0] reg_rdata;
	logic       reg_rvalid;
	logic [7:0] next_reg_rdata;
	logic       next_reg_rvalid;

	// Output stage state
	logic [NUM_ROWS-1:0]  row_switch_control;
	logic [NUM_ROWS-1:0]  next_row_switch_control;
	logic [NUM_LINES-1:0] line_const_mode;
	logic [NUM_LINES-1:0] next_line_const_mode;
	logic [3:0]           last_col;
	logic [3:0]           next_last_col;

	logic [NUM_ROWS-1:0]  row_mask_enable;
	logic [NUM_LINES-1:0] const_force;
	logic [3:0]           col_idx;

	if (NUM_ROWS != 12 || NUM_LINES != 13) begin : g_bad_geometry
		$error("row mask logic is laid out for twelve rows and thirteen lines");
	end

	assign row_mask_enable = {row_mask_high_rows, row_mask_low_rows};
	assign const_force     = {const_force_high, const_force_low};

	// Register writes
	always_comb begin
		next_const_force_low    = const_force_low;
		next_const_force_high   = const_force_high;
		next_row_mask_low_rows  = row_mask_low_rows;
		next_row_mask_high_rows = row_mask_high_rows;
		next_row_mask_level     = row_mask_level;
		next_column_scan_count  = column_scan_count;
		if (reg_req_i.wr) begin
			case (reg_req_i.addr)
				ADDR_CONST_FORCE_LOW: begin
					next_const_force_low = reg_req_i.wdata;
				end
				ADDR_CONST_FORCE_HIGH: begin
					next_const_force_high = reg_req_i.wdata[CONST_FORCE_HIGH_W-1:0];
				end
				ADDR_ROW_MASK_LOW: begin
					next_row_mask_low_rows = reg_req_i.wdata;
				end
				ADDR_ROW_MASK_HIGH: begin
					next_row_mask_high_rows =
						reg_req_i.wdata[ROW_MASK_HIGH_LSB +: ROW_MASK_HIGH_W];
					next_row_mask_level = reg_req_i.wdata[ROW_MASK_LEVEL_POS];
				end
				ADDR_COL_SCAN_COUNT: begin
					next_column_scan_count = reg_req_i.wdata[COL_SCAN_LSB +: COL_SCAN_W];
				end
				default: begin
					next_column_scan_count = column_scan_count;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			const_force_low    <= RST_CONST_FORCE_LOW;
			const_force_high   <= RST_CONST_FORCE_HIGH;
			row_mask_low_rows  <= RST_ROW_MASK_LOW;
			row_mask_high_rows <= RST_ROW_MASK_HIGH;
			row_mask_level     <= RST_ROW_MASK_LEVEL;
			column_scan_count  <= RST_COL_SCAN_COUNT;
		end else begin
			const_force_low    <= next_const_force_low;
			const_force_high   <= next_const_force_high;
			row_mask_low_rows  <= next_row_mask_low_rows;
			row_mask_high_rows <= next_row_mask_high_rows;
			row_mask_level     <= next_row_mask_level;
			column_scan_count  <= next_column_scan_count;
		end
	end

	// Register reads; reserved bits and unmapped addresses return zero
	always_comb begin
		next_reg_rvalid = reg_req_i.rd;
		next_reg_rdata  = 8'h00;
		if (reg_req_i.rd) begin
			case (reg_req_i.addr)
				ADDR_CONST_FORCE_LOW:  next_reg_rdata = const_force_low;
				ADDR_CONST_FORCE_HIGH: next_reg_rdata = {3'h0, const_force_high};
				ADDR_ROW_MASK_LOW:     next_reg_rdata = row_mask_low_rows;
				ADDR_ROW_MASK_HIGH:    next_reg_rdata = {3'h0, row_mask_level,
					row_mask_high_rows};
				ADDR_COL_SCAN_COUNT:   next_reg_rdata = {4'h0, column_scan_count};
				default:               next_reg_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rdata  <= next_reg_rdata;
			reg_rvalid <= next_reg_rvalid;
		end
	end

	// Effective last column
	always_comb begin
		if (scroll_active_i || detect_en_i)
			next_last_col = COL_LAST_ALL;
		else if (column_scan_count >= COL_LAST_ALL)
			next_last_col = COL_LAST_ALL;
		else
			next_last_col = column_scan_count;
	end

	// Row output stage; constant force on a line cancels its mask
	always_comb begin
		next_line_const_mode = const_force;
		for (int i = 0; i < NUM_ROWS; i++) begin
			if (row_mask_enable[i] && !const_force[i])
				next_row_switch_control[i] = row_mask_level;
			else
				next_row_switch_control[i] = matrix_row_ctrl_i[i];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			row_switch_control <= '0;
			line_const_mode    <= '0;
			last_col           <= COL_LAST_ALL;
		end else begin
			row_switch_control <= next_row_switch_control;
			line_const_mode    <= next_line_const_mode;
			last_col           <= next_last_col;
		end
	end

	// Counter sees only the scan limit, never the mask bits
	col_scan_counter #(
		.COL_W(4)
	) u_col_scan (
		.clk_sys_i  (clk_sys_i),
		.rst_n_i    (rst_n_i),
		.scan_tick_i(scan_tick_i),
		.last_col_i (last_col),
		.col_idx_o  (col_idx)
	);

	assign reg_rdata_o          = reg_rdata;
	assign reg_rvalid_o         = reg_rvalid;
	assign row_switch_control_o = row_switch_control;
	assign line_const_mode_o    = line_const_mode;
	assign col_idx_o            = col_idx;

	mask_low_rows_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		reg_req_i.wr && reg_req_i.addr == ADDR_ROW_MASK_LOW
		|=> row_mask_low_rows == $past(reg_req_i.wdata))
		else $error("low row mask write not stored");

	mask_high_rows_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		reg_req_i.wr && reg_req_i.addr == ADDR_ROW_MASK_HIGH
		|=> row_mask_high_rows == $past(reg_req_i.wdata[3:0]))
		else $error("high row mask write not stored");

	masked_row_level_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		row_mask_enable[0] && !const_force[0]
		|=> row_switch_control[0] == $past(row_mask_level))
		else $error("masked row not held at mask level");

	mask_low_drive_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		row_mask_enable[11] && !const_force[11] && !row_mask_level
		|=> !row_switch_control[11])
		else $error("masked row not driven low");

	mask_high_drive_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		row_mask_enable[5] && !const_force[5] && row_mask_level
		|=> row_switch_control[5])
		else $error("masked row not driven high");

	const_precedence_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		const_force[3] |=> row_switch_control[3] == $past(matrix_row_ctrl_i[3])
			&& line_const_mode[3])
		else $error("constant force did not override row mask");

	scan_limit_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		!scroll_active_i && !detect_en_i && column_scan_count < COL_LAST_ALL
		|=> last_col == $past(column_scan_count))
		else $error("scan limit does not follow the field");

	scan_all_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		column_scan_count >= COL_LAST_ALL |=> last_col == COL_LAST_ALL)
		else $error("out of range field did not scan all columns");

	scroll_all_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		scroll_active_i || detect_en_i |=> last_col == COL_LAST_ALL)
		else $error("scroll or detect did not force all columns");

	col_bound_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		scan_tick_i |=> col_idx <= $past(last_col))
		else $error("column index passed the scan limit");

	scan_step_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		scan_tick_i && col_idx < last_col
		|=> col_idx == $past(col_idx) + 4'h1)
		else $error("column index did not advance by one");

	col_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		!scan_tick_i |=> $stable(col_idx))
		else $error("column index moved without a scan tick");

	scan_field_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		reg_req_i.wr && reg_req_i.addr == ADDR_COL_SCAN_COUNT
		|=> column_scan_count == $past(reg_req_i.wdata[COL_SCAN_LSB +: COL_SCAN_W]))
		else $error("scan field write not stored");

	level_store_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		reg_req_i.wr && reg_req_i.addr == ADDR_ROW_MASK_HIGH
		|=> row_mask_level == $past(reg_req_i.wdata[ROW_MASK_LEVEL_POS]))
		else $error("mask level write not stored");

	line_mode_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		1'b1 |=> line_const_mode == $past(const_force))
		else $error("line mode does not follow the force bits");

	// Register port answers
	read_answer_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		reg_req_i.rd |=> reg_rvalid)
		else $error("read not answered in the next cycle");

	read_idle_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		!reg_req_i.rd |=> !reg_rvalid && reg_rdata == 8'h00)
		else $error("read data shown without a read");

	scan_read_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		reg_req_i.rd && reg_req_i.addr == ADDR_COL_SCAN_COUNT
		|=> reg_rdata == {4'h0, $past(column_scan_count)})
		else $error("scan field read back wrong");

	high_read_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		reg_req_i.rd && reg_req_i.addr == ADDR_ROW_MASK_HIGH
		|=> reg_rdata == {3'h0, $past(row_mask_level), $past(row_mask_high_rows)})
		else $error("high row mask read back wrong");

	// Every row, not only the sampled ones
	for (genvar r = 0; r < NUM_ROWS; r++) begin : g_row_chk
		row_mask_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
			row_mask_enable[r] && !const_force[r]
			|=> row_switch_control[r] == $past(row_mask_level))
			else $error("row under mask left the mask level");

		row_pass_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
			!row_mask_enable[r] || const_force[r]
			|=> row_switch_control[r] == $past(matrix_row_ctrl_i[r]))
			else $error("unmasked row did not follow the scan logic");
	end

endmodule

// File: dv/led_matrix_row_mask_scan_ctrl_tb.sv
module led_matrix_row_mask_scan_ctrl_tb
	import led_scan_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk_sys_i, rst_n_i, scan_tick_i, scroll_active_i, detect_en_i;
	reg_req_s    reg_req_i;
	logic [11:0] mrc, rows;
	logic [12:0] lines;
	logic [7:0]  rdata, c77, c78, m79, m7a;
	logic        rvalid;
	logic [3:0]  col, exp_col, last, f;
	int          fail_count, num_checks, cycles;

	led_matrix_row_mask_scan_ctrl uut (
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_req_i(reg_req_i),
		.scan_tick_i(scan_tick_i), .scroll_active_i(scroll_active_i),
		.detect_en_i(detect_en_i), .matrix_row_ctrl_i(mrc), .reg_rdata_o(rdata),
		.reg_rvalid_o(rvalid), .row_switch_control_o(rows),
		.line_const_mode_o(lines), .col_idx_o(col));

	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end

	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic final_report();
		$display("Checks made %0d, mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	always @(posedge clk_sys_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			final_report();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		reg_req_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_sys_i);
		reg_req_i <= '0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys_i);
		reg_req_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk_sys_i);
		reg_req_i <= '0;
		#1;
		check("rvalid", {15'h0000, rvalid}, 16'h0001);
		check("rdata", {8'h00, rdata}, {8'h00, exp});
		@(posedge clk_sys_i);
		#1;
		check("rvalid_idle", {15'h0000, rvalid}, 16'h0000);
		check("rdata_idle", {8'h00, rdata}, 16'h0000);
	endtask

	function automatic logic [11:0] exp_row(logic [11:0] mk, logic [11:0] cs,
			logic [11:0] mr, logic lv);
		for (int i = 0; i < 12; i++) exp_row[i] = (mk[i] & ~cs[i]) ? lv : mr[i];
	endfunction

	initial begin
		rst_n_i = 1'b0;
		reg_req_i = '0;
		scan_tick_i = 1'b0;
		scroll_active_i = 1'b0;
		detect_en_i = 1'b0;
		mrc = 12'h000;
		fail_count = 0;
		num_checks = 0;
		cycles = 0;
		exp_col = 4'h0;
		void'($urandom(16283));
		repeat (20) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		#1;
		check("rows_rst", {4'h0, rows}, 16'h0000);
		check("col_rst", {12'h000, col}, 16'h0000);
		rd(8'h79, 8'h00);
		rd(8'h7A, 8'h00);
		rd(8'h7E, 8'h0B);
		rd(8'h78, 8'h00);
		wr(8'h7A, 8'hFF);
		rd(8'h7A, 8'h1F);
		wr(8'h7E, 8'hFF);
		rd(8'h7E, 8'h0F);
		rd(8'h7B, 8'h00);
		$display("Register test done");
		for (int i = 0; i < 24; i++) begin
			c77 = 8'($urandom);
			c78 = 8'($urandom);
			m79 = 8'($urandom);
			m7a = 8'($urandom);
			if (i == 0) {c77, c78, m79, m7a} = 32'h0000_FF13;
			if (i == 1) {c77, c78, m79, m7a} = 32'h0F1F_AA0F;
			wr(8'h77, c77);
			wr(8'h78, c78);
			wr(8'h79, m79);
			wr(8'h7A, m7a);
			rd(8'h79, m79);
			@(posedge clk_sys_i);
			mrc <= 12'($urandom);
			repeat (2) @(posedge clk_sys_i);
			#1;
			check("rows", {4'h0, rows}, {4'h0, exp_row({m7a[3:0], m79},
				{c78[3:0], c77}, mrc, m7a[4])});
			check("lines", {3'h0, lines}, {3'h0, c78[4:0], c77});
		end
		$display("Row mask test done");
		for (int k = 0; k < 18; k++) begin
			f = (k < 16) ? 4'(k) : 4'h3;
			wr(8'h7E, {4'h0, f});
			@(posedge clk_sys_i);
			scroll_active_i <= (k == 16);
			detect_en_i <= (k == 17);
			repeat (2) @(posedge clk_sys_i);
			last = (k >= 16 || f >= 4'hB) ? 4'hB : f;
			for (int t = 0; t < 14; t++) begin
				@(posedge clk_sys_i);
				scan_tick_i <= 1'b1;
				@(posedge clk_sys_i);
				scan_tick_i <= 1'b0;
				#1;
				exp_col = (exp_col >= last) ? 4'h0 : exp_col + 4'h1;
				check("col", {12'h000, col}, {12'h000, exp_col});
			end
		end
		$display("Scan test done");
		@(posedge clk_sys_i);
		rst_n_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		#1;
		check("rows_rst2", {4'h0, rows}, 16'h0000);
		check("lines_rst2", {3'h0, lines}, 16'h0000);
		check("col_rst2", {12'h000, col}, 16'h0000);
		rd(8'h7E, 8'h0B);
		rd(8'h79, 8'h00);
		rd(8'h7A, 8'h00);
		$display("Reset test done");
		final_report();
	end
endmodule
